// ### design/icf_cache.v
// instruction fetch cache with block fill, lru ways, fence flush and register slave
// ********************
// ********************
`timescale 1ns/100ps
`include "icf_map.vh"
module icf_cache #(
   parameter CACHE_EN   = 1,
   parameter NUM_BLOCKS = 4,
   parameter BLOCK_SIZE = 64,
   parameter ASSOC      = 1,
   parameter BUS_TMO    = `ICF_TMO_DEF
) (
   // clock and reset
   input  wire                  clk_sys,
   input  wire                  reset_n,
   // core fetch side
   input  wire                  cpu_req,
   input  wire [31:0]           cpu_addr,
   input  wire                  cpu_fence_i,
   output wire                  cpu_ack,
   output wire                  cpu_err,
   output wire [31:0]           cpu_rdata,
   // system bus side
   output wire                  bus_req,
   output wire [31:0]           bus_addr,
   input  wire                  bus_ack,
   input  wire                  bus_err,
   input  wire [31:0]           bus_rdata,
   // register bus, axi4-lite slave
   input  wire [`ICF_AXI_AW-1:0] s_axi_awaddr,
   input  wire                  s_axi_awvalid,
   output wire                  s_axi_awready,
   input  wire [31:0]           s_axi_wdata,
   input  wire [3:0]            s_axi_wstrb,
   input  wire                  s_axi_wvalid,
   output wire                  s_axi_wready,
   output wire [1:0]            s_axi_bresp,
   output wire                  s_axi_bvalid,
   input  wire                  s_axi_bready,
   input  wire [`ICF_AXI_AW-1:0] s_axi_araddr,
   input  wire                  s_axi_arvalid,
   output wire                  s_axi_arready,
   output wire [31:0]           s_axi_rdata,
   output wire [1:0]            s_axi_rresp,
   output wire                  s_axi_rvalid,
   input  wire                  s_axi_rready,
   // interrupt
   output wire                  irq
);

   // ********************
   // geometry
   // ********************
   function integer clog2;
      input integer v;
      integer k;
      begin
         k = 0;
         while ((1 << k) < v) begin
            k = k + 1;
         end
         clog2 = k;
      end
   endfunction

   localparam WAYS   = ASSOC;
   localparam WPB    = BLOCK_SIZE / 4;
   localparam LINES  = NUM_BLOCKS / ASSOC;
   localparam OFS_B  = clog2(WPB);
   localparam IDX_B  = clog2(LINES);
   localparam MEM_B  = OFS_B + IDX_B;
   localparam IDX_W  = (IDX_B < 1) ? 1 : IDX_B;
   localparam MEM_W  = (MEM_B < 1) ? 1 : MEM_B;
   localparam AGE_W  = (clog2(WAYS) < 1) ? 1 : clog2(WAYS);
   localparam TAG_SH = `ICF_WORD_SH + MEM_B;

   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_FILL = 4'h2;
   localparam [3:0] S_BYP  = 4'h4;
   localparam [3:0] S_RESP = 4'h8;

   // address slices used by lookup and fill
   wire [31:0] mem_mask  = LINES * WPB - 1;
   wire [31:0] line_mask = LINES - 1;
   wire [31:0] ofs_mask  = WPB - 1;
   wire [31:0] blk_mask  = BLOCK_SIZE - 1;
   wire [31:0] tmo_lim   = BUS_TMO;
   wire [31:0] age_top   = WAYS - 1;
   wire [31:0] cpu_mem32 = (cpu_addr >> `ICF_WORD_SH) & mem_mask;
   wire [31:0] cpu_lin32 = (cpu_addr >> (`ICF_WORD_SH + OFS_B)) & line_mask;
   wire [31:0] cpu_tag   = cpu_addr >> TAG_SH;

   // ********************
   // state
   // ********************
   reg [3:0]       state_q;
   reg             ack_q, err_q, req_q, fill_err_q, fence_pend_q;
   reg [31:0]      rdata_q, baddr_q, tmo_q;
   reg [31:0]      vic_q;
   reg [AGE_W-1:0] age_q [0:LINES*WAYS-1];

   wire [31:0] fil_mem32 = (baddr_q >> `ICF_WORD_SH) & mem_mask;
   wire [31:0] fil_lin32 = (baddr_q >> (`ICF_WORD_SH + OFS_B)) & line_mask;
   wire [31:0] fil_word  = (baddr_q >> `ICF_WORD_SH) & ofs_mask;
   wire        beat_done = req_q & (bus_ack | bus_err | (tmo_q == tmo_lim));
   wire        beat_bad  = bus_err | ~bus_ack;         // timeout counts as failure
   wire        fill_last = (fil_word == ofs_mask);

   // register bus state
   reg         byp_q, sw_flush_q, irq_q;
   reg [`ICF_ST_W-1:0] stat_q, mask_q;

   wire        fill_end  = (state_q == S_FILL) & beat_done & fill_last;
   wire        flush_go  = (state_q == S_IDLE) & fence_pend_q;

   // ********************
   // ways
   // ********************
   wire [WAYS-1:0]    way_pres, way_err, way_hit;
   wire [WAYS*32-1:0] way_data;

   genvar w;
   generate
      if (CACHE_EN != 0) begin : g_cache
         for (w = 0; w < WAYS; w = w + 1) begin : g_way
            wire [31:0] tag_w;
            icf_way #(
               .LINES (LINES),
               .WPB   (WPB),
               .IDX_W (IDX_W),
               .MEM_W (MEM_W)
            ) u_way (
               .clk_sys  (clk_sys),
               .reset_n  (reset_n),
               .flush    (flush_go),
               .rd_line  (cpu_lin32[IDX_W-1:0]),
               .rd_mem   (cpu_mem32[MEM_W-1:0]),
               .wr_en    ((state_q == S_FILL) & beat_done & (vic_q == w)),
               .wr_mem   (fil_mem32[MEM_W-1:0]),
               .wr_data  (bus_rdata),
               .tag_we   (fill_end & (vic_q == w)),
               .tag_line (fil_lin32[IDX_W-1:0]),
               .tag_in   (baddr_q >> TAG_SH),
               .tag_err  (fill_err_q | beat_bad),
               .present  (way_pres[w]),
               .err      (way_err[w]),
               .tag      (tag_w),
               .data     (way_data[w*32 +: 32])
            );
            assign way_hit[w] = way_pres[w] & (tag_w == cpu_tag);
         end
      end else begin : g_nocache
         // no storage at all; the fetch path below always takes the bypass
         assign way_pres = {WAYS{1'b0}};
         assign way_err  = {WAYS{1'b0}};
         assign way_hit  = {WAYS{1'b0}};
         assign way_data = {(WAYS*32){1'b0}};
      end
   endgenerate

   // ********************
   // hit select and victim choice
   // ********************
   reg [31:0] hit_way, vic_d, hit_data;
   reg        hit_any, hit_bad;
   integer    k;
   // an empty way is taken first, otherwise the oldest one
   always @* begin
      hit_way  = `ICF_ZERO32;
      vic_d    = `ICF_ZERO32;
      hit_data = `ICF_ZERO32;
      hit_any  = 1'b0;
      hit_bad  = 1'b0;
      for (k = WAYS - 1; k >= 0; k = k - 1) begin
         if (way_hit[k]) begin
            hit_way  = k;
            hit_any  = 1'b1;
            hit_bad  = way_err[k];
            hit_data = way_data[k*32 +: 32];
         end
         if (age_q[cpu_lin32*WAYS + k] == age_top[AGE_W-1:0]) begin
            vic_d = k;
         end
      end
      for (k = WAYS - 1; k >= 0; k = k - 1) begin
         if (!way_pres[k]) begin
            vic_d = k;
         end
      end
   end

   // ********************
   // lru ages
   // ********************
   function [AGE_W-1:0] age_of;
      input integer i;
      integer t;
      begin
         t = i % WAYS;
         age_of = t[AGE_W-1:0];
      end
   endfunction

   wire        touch     = fill_end | ((state_q == S_IDLE) & cpu_req & ~fence_pend_q &
                                       ~byp_q & (CACHE_EN != 0) & hit_any);
   wire [31:0] t_line    = fill_end ? fil_lin32 : cpu_lin32;
   wire [31:0] t_way     = fill_end ? vic_q : hit_way;
   wire [AGE_W-1:0] t_age = age_q[t_line*WAYS + t_way];

   integer i;
   // touched way becomes youngest, younger ones of that line age by one
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (i = 0; i < LINES*WAYS; i = i + 1) begin
            age_q[i] <= age_of(i);
         end
      end else if (touch) begin
         for (i = 0; i < LINES*WAYS; i = i + 1) begin
            if ((i / WAYS) == t_line) begin
               if ((i % WAYS) == t_way) begin
                  age_q[i] <= {AGE_W{1'b0}};
               end else if (age_q[i] < t_age) begin
                  age_q[i] <= age_q[i] + 1'b1;
               end
            end
         end
      end
   end

   // ********************
   // fetch state machine
   // ********************
   // a pending flush is served before any lookup so no stale word escapes
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_q      <= S_IDLE;
         ack_q        <= 1'b0;
         err_q        <= 1'b0;
         rdata_q      <= `ICF_ZERO32;
         req_q        <= 1'b0;
         baddr_q      <= `ICF_ZERO32;
         tmo_q        <= `ICF_ZERO32;
         vic_q        <= `ICF_ZERO32;
         fill_err_q   <= 1'b0;
         fence_pend_q <= 1'b0;
      end else begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
         // a new fence wins over the clear of the old one
         fence_pend_q <= (fence_pend_q & ~flush_go) | cpu_fence_i | sw_flush_q;
         tmo_q <= req_q ? tmo_q + 32'h0000_0001 : `ICF_ZERO32;
         case (state_q)
            S_IDLE: begin
               if (fence_pend_q) begin
                  state_q <= S_IDLE;
               end else if (cpu_req & ((CACHE_EN == 0) | byp_q)) begin
                  baddr_q <= (cpu_addr >> `ICF_WORD_SH) << `ICF_WORD_SH;
                  req_q   <= 1'b1;
                  state_q <= S_BYP;
               end else if (cpu_req & hit_any) begin
                  ack_q   <= ~hit_bad;
                  err_q   <= hit_bad;
                  rdata_q <= hit_data;
                  state_q <= S_RESP;
               end else if (cpu_req) begin
                  baddr_q    <= cpu_addr & ~blk_mask;
                  vic_q      <= vic_d;
                  fill_err_q <= 1'b0;
                  req_q      <= 1'b1;
                  state_q    <= S_FILL;
               end
            end
            S_FILL: begin
               if (beat_done) begin
                  req_q      <= 1'b0;
                  fill_err_q <= fill_err_q | beat_bad;
                  if (fill_last) begin
                     state_q <= S_IDLE;                 // relook now hits the new line
                  end else begin
                     baddr_q <= baddr_q + `ICF_WORD_INC;
                  end
               end else if (!req_q) begin
                  req_q <= 1'b1;
               end
            end
            S_BYP: begin
               if (beat_done) begin
                  req_q   <= 1'b0;
                  ack_q   <= ~beat_bad;
                  err_q   <= beat_bad;
                  rdata_q <= bus_rdata;
                  state_q <= S_RESP;
               end
            end
            S_RESP: begin
               // one quiet cycle lets the core drop its request
               state_q <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   assign cpu_ack   = ack_q;
   assign cpu_err   = err_q;
   assign cpu_rdata = rdata_q;
   assign bus_req   = req_q;
   assign bus_addr  = baddr_q;

   // ********************
   // register slave
   // ********************
   reg        awr_q, wr_q, bval_q, arr_q, rval_q, aw_got_q, w_got_q;
   reg [1:0]  bresp_q, rresp_q;
   reg [31:0] rd_q, wdat_q;
   reg [`ICF_AXI_AW-1:0] awa_q;
   reg [3:0]  strb_q;
   reg [31:0] conf_w;

   // one decoder serves both the write and the read path
   function addr_ok;
      input [`ICF_AXI_AW-1:0] a;
      begin
         addr_ok = (a == `ICF_REG_CTRL) | (a == `ICF_REG_STAT) |
                   (a == `ICF_REG_MASK) | (a == `ICF_REG_CONF);
      end
   endfunction

   // the logs are small, so each is cut to its field width on purpose
   localparam [31:0] LG_BS = clog2(BLOCK_SIZE);
   localparam [31:0] LG_NB = clog2(NUM_BLOCKS);
   localparam [31:0] LG_AS = clog2(ASSOC);

   // read-only build description
   always @* begin
      conf_w = `ICF_ZERO32;
      conf_w[`ICF_CONF_BS_LSB +: `ICF_CONF_FLD_W] = LG_BS[`ICF_CONF_FLD_W-1:0];
      conf_w[`ICF_CONF_NB_LSB +: `ICF_CONF_FLD_W] = LG_NB[`ICF_CONF_FLD_W-1:0];
      conf_w[`ICF_CONF_AS_LSB +: `ICF_CONF_FLD_W] = LG_AS[`ICF_CONF_FLD_W-1:0];
      conf_w[`ICF_CONF_EN_BIT] = (CACHE_EN != 0);
   end

   wire do_wr = aw_got_q & w_got_q & ~bval_q;
   wire wr_lo = do_wr & strb_q[0] & addr_ok(awa_q);
   wire [`ICF_ST_W-1:0] ev = {flush_go, fill_end & (fill_err_q | beat_bad)};
   wire [`ICF_ST_W-1:0] clr = (wr_lo & (awa_q == `ICF_REG_STAT)) ?
                              wdat_q[`ICF_ST_W-1:0] : `ICF_STAT_RST;
   wire [`ICF_ST_W-1:0] stat_d = (stat_q & ~clr) | ev;   // event wins over clear

   // address and data may arrive in either order; answer after both
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         awr_q <= 1'b1;
         wr_q <= 1'b1;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         bval_q <= 1'b0;
         bresp_q <= `ICF_RESP_OKAY;
         awa_q <= {`ICF_AXI_AW{1'b0}};
         wdat_q <= `ICF_ZERO32;
         strb_q <= 4'h0;
         arr_q <= 1'b1;
         rval_q <= 1'b0;
         rresp_q <= `ICF_RESP_OKAY;
         rd_q <= `ICF_ZERO32;
         byp_q <= 1'b0;
         sw_flush_q <= 1'b0;
         mask_q <= `ICF_MASK_RST;
         stat_q <= `ICF_STAT_RST;
         irq_q <= 1'b0;
      end else begin
         sw_flush_q <= 1'b0;
         stat_q <= stat_d;
         irq_q  <= |(stat_d & mask_q);
         if (s_axi_awvalid & awr_q) begin
            awa_q    <= s_axi_awaddr;
            aw_got_q <= 1'b1;
            awr_q    <= 1'b0;
         end
         if (s_axi_wvalid & wr_q) begin
            wdat_q  <= s_axi_wdata;
            strb_q  <= s_axi_wstrb;
            w_got_q <= 1'b1;
            wr_q    <= 1'b0;
         end
         if (do_wr) begin
            bval_q  <= 1'b1;
            bresp_q <= addr_ok(awa_q) ? `ICF_RESP_OKAY : `ICF_RESP_SLVERR;
            if (wr_lo & (awa_q == `ICF_REG_CTRL)) begin
               byp_q      <= wdat_q[`ICF_CTRL_BYPASS];
               sw_flush_q <= wdat_q[`ICF_CTRL_FLUSH];
            end
            if (wr_lo & (awa_q == `ICF_REG_MASK)) begin
               mask_q <= wdat_q[`ICF_ST_W-1:0];
            end
         end
         if (bval_q & s_axi_bready) begin
            bval_q   <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awr_q    <= 1'b1;
            wr_q     <= 1'b1;
         end
         // read path; flush bit reads back as zero
         if (s_axi_arvalid & arr_q) begin
            arr_q   <= 1'b0;
            rval_q  <= 1'b1;
            rresp_q <= addr_ok(s_axi_araddr) ? `ICF_RESP_OKAY : `ICF_RESP_SLVERR;
            case (s_axi_araddr)
               `ICF_REG_CTRL: rd_q <= {30'h0, byp_q, 1'b0};
               `ICF_REG_STAT: rd_q <= {30'h0, stat_q};
               `ICF_REG_MASK: rd_q <= {30'h0, mask_q};
               `ICF_REG_CONF: rd_q <= conf_w;
               default:       rd_q <= `ICF_ZERO32;
            endcase
         end
         if (rval_q & s_axi_rready) begin
            rval_q <= 1'b0;
            arr_q  <= 1'b1;
         end
      end
   end

   assign s_axi_awready = awr_q;
   assign s_axi_wready  = wr_q;
   assign s_axi_bvalid  = bval_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arr_q;
   assign s_axi_rvalid  = rval_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rd_q;
   assign irq           = irq_q;

endmodule

// ### design/icf_map.vh
// register map, field positions and reset values of the instruction fetch cache
`ifndef ICF_MAP_VH
`define ICF_MAP_VH

// ********************
// register bus layout
// ********************
`define ICF_AXI_AW        8
`define ICF_REG_CTRL      8'h00
`define ICF_REG_STAT      8'h04
`define ICF_REG_MASK      8'h08
`define ICF_REG_CONF      8'h0C
`define ICF_RESP_OKAY     2'h0
`define ICF_RESP_SLVERR   2'h2

// ********************
// field positions
// ********************
`define ICF_CTRL_FLUSH    0
`define ICF_CTRL_BYPASS   1
`define ICF_ST_FILLERR    0
`define ICF_ST_FLUSHED    1
`define ICF_ST_W          2
`define ICF_CONF_FLD_W    4
`define ICF_CONF_BS_LSB   0
`define ICF_CONF_NB_LSB   4
`define ICF_CONF_AS_LSB   8
`define ICF_CONF_EN_BIT   12

// ********************
// reset values and constants
// ********************
`define ICF_ZERO32        32'h0000_0000
`define ICF_MASK_RST      2'h0
`define ICF_STAT_RST      2'h0
`define ICF_WORD_INC      32'h0000_0004
`define ICF_WORD_SH       2
`define ICF_TMO_DEF       255

`endif

// ### design/icf_way.v
// one way of the instruction fetch cache: tags, line flags and instruction words
`timescale 1ns/100ps
module icf_way #(
   parameter LINES = 4,
   parameter WPB   = 16,
   parameter IDX_W = 2,
   parameter MEM_W = 6
) (
   // clock and reset
   input  wire             clk_sys,
   input  wire             reset_n,
   // whole-way invalidate
   input  wire             flush,
   // lookup port
   input  wire [IDX_W-1:0] rd_line,
   input  wire [MEM_W-1:0] rd_mem,
   // fill port
   input  wire             wr_en,
   input  wire [MEM_W-1:0] wr_mem,
   input  wire [31:0]      wr_data,
   input  wire             tag_we,
   input  wire [IDX_W-1:0] tag_line,
   input  wire [31:0]      tag_in,
   input  wire             tag_err,
   // lookup results
   output wire             present,
   output wire             err,
   output wire [31:0]      tag,
   output wire [31:0]      data
);

   reg [31:0]      mem_q [0:LINES*WPB-1];
   reg [31:0]      tag_q [0:LINES-1];
   reg [LINES-1:0] pres_q;
   reg [LINES-1:0] err_q;

   // ********************
   // storage arrays
   // ********************
   // arrays carry no reset; the presence flags alone decide what may hit
   always @(posedge clk_sys) begin
      if (wr_en) begin
         mem_q[wr_mem] <= wr_data;
      end
      if (tag_we) begin
         tag_q[tag_line] <= tag_in;
      end
   end

   // presence and poison flags; a flush wins over a tag write in the same cycle
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pres_q <= {LINES{1'b0}};
         err_q  <= {LINES{1'b0}};
      end else if (flush) begin
         pres_q <= {LINES{1'b0}};
         err_q  <= {LINES{1'b0}};
      end else if (tag_we) begin
         pres_q[tag_line] <= 1'b1;
         err_q[tag_line]  <= tag_err;
      end
   end

   // lookup reads are combinational
   assign present = pres_q[rd_line];
   assign err     = err_q[rd_line];
   assign tag     = tag_q[rd_line];
   assign data    = mem_q[rd_mem];

endmodule

// ### sim/icf_cache_assertions.sv
// checker for the fetch, system bus and register bus ports of the cache
`timescale 1ns/100ps
module icf_cache_chk #(
   parameter BUS_TMO = 255
) (
   // clock and reset
   input wire        clk_sys,
   input wire        reset_n,
   // fetch and system bus
   input wire        cpu_req,
   input wire        cpu_ack,
   input wire        cpu_err,
   input wire        bus_req,
   input wire [31:0] bus_addr,
   input wire        bus_ack,
   input wire        bus_err,
   // register bus answers
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata
);
   reg [15:0] wait_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence s_beat; bus_req && (bus_ack || bus_err); endsequence
   sequence s_fetch; cpu_req ##1 (cpu_ack || cpu_err); endsequence
   // length of the current unanswered bus read, bounded by the timeout
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) wait_q <= 16'h0000;
      else if (bus_req && !bus_ack && !bus_err) wait_q <= wait_q + 16'h0001;
      else wait_q <= 16'h0000;
   end
   a_ans_excl: assert property (!(cpu_ack && cpu_err))
      else $error("fetch answered ok and error at once");
   a_ans_pulse: assert property (s_fetch |=> !cpu_ack && !cpu_err)
      else $error("fetch answer longer than one cycle");
   a_ans_cause: assert property ((cpu_ack || cpu_err) |-> $past(cpu_req))
      else $error("fetch answer without request");
   a_beat_drop: assert property (s_beat |=> !bus_req)
      else $error("bus request kept after answer");
   a_addr_hold: assert property (bus_req && $past(bus_req) |-> $stable(bus_addr))
      else $error("bus address moved during read");
   a_addr_word: assert property (bus_req |-> bus_addr[1:0] == 2'h0)
      else $error("bus address not word aligned");
   a_bus_cause: assert property ($rose(bus_req) |-> $past(cpu_req))
      else $error("bus read without a fetch");
   a_tmo_bound: assert property (wait_q <= BUS_TMO + 2)
      else $error("bus read outlived the timeout");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped early");
endmodule
bind icf_cache icf_cache_chk #(.BUS_TMO(BUS_TMO)) u_chk (.clk_sys, .reset_n, .cpu_req, .cpu_ack,
   .cpu_err, .bus_req, .bus_addr, .bus_ack, .bus_err, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// ### sim/icf_mem.sv
// behavioural system bus memory answering the cache's block reads
`timescale 1ns/100ps
module icf_mem (
   // clock
   input wire        clk_sys,
   // read request from the cache
   input wire        bus_req,
   input wire [31:0] bus_addr,
   // bench controls: error word, silent word, answer delay
   input wire [31:0] err_addr,
   input wire [31:0] mute_addr,
   input wire [3:0]  lat,
   // answer
   output reg        bus_ack = 1'b0,
   output reg        bus_err = 1'b0,
   output reg [31:0] bus_rdata = 32'h0000_0000
);
   reg [3:0] cnt_q = 4'h0;
   // data toggles outside a beat so a stale word is never mistaken for good
   always @(posedge clk_sys) begin
      bus_ack <= 1'b0;
      bus_err <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (!bus_req || bus_ack || bus_err) cnt_q <= 4'h0;
      else if (cnt_q < lat) cnt_q <= cnt_q + 4'h1;
      else if (bus_addr == err_addr) bus_err <= 1'b1;
      else if (bus_addr != mute_addr) begin
         bus_ack <= 1'b1;
         bus_rdata <= bus_addr ^ 32'hA5A5_0000;
      end
   end
endmodule

// ### sim/testbench.sv
// self-checking bench of the instruction fetch cache
`timescale 1ns/100ps
`include "icf_map.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
   $display("Error %0t got %h expected %h", $time, g, e); end end
module testbench;
   reg        clk_sys = 1'b0;
   reg        reset_n = 1'b0;
   reg        cpu_req = 1'b0;
   reg [31:0] cpu_addr = 32'h0000_0000;
   reg        cpu_fence_i = 1'b0;
   reg [7:0]  s_axi_awaddr = 8'h00;
   reg [7:0]  s_axi_araddr = 8'h00;
   reg [31:0] s_axi_wdata = 32'h0000_0000;
   reg [3:0]  s_axi_wstrb = 4'hF;
   reg        s_axi_awvalid = 1'b0;
   reg        s_axi_wvalid = 1'b0;
   reg        s_axi_bready = 1'b0;
   reg        s_axi_arvalid = 1'b0;
   reg        s_axi_rready = 1'b0;
   reg [31:0] err_addr = 32'hFFFF_FFF0;
   reg [31:0] mute_addr = 32'hFFFF_FFF0;
   reg [3:0]  lat = 4'h0;
   integer    num_errors = 0;
   integer    n_compared = 0;
   integer    beats = 0;
   reg [31:0] prev_a = 32'h0000_0000;
   reg [31:0] last_a = 32'h0000_0000;
   wire        cpu_ack, cpu_err, bus_req, bus_ack, bus_err, irq;
   wire [31:0] cpu_rdata, bus_addr, bus_rdata, s_axi_rdata;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   // ********************
   // design, far side and clock
   // ********************
   icf_cache #(.NUM_BLOCKS(4), .BLOCK_SIZE(8), .ASSOC(2), .BUS_TMO(8)) uut (.clk_sys, .reset_n,
      .cpu_req, .cpu_addr, .cpu_fence_i, .cpu_ack, .cpu_err, .cpu_rdata, .bus_req, .bus_addr,
      .bus_ack, .bus_err, .bus_rdata, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .irq);
   icf_mem u_mem (.clk_sys, .bus_req, .bus_addr, .err_addr, .mute_addr, .lat, .bus_ack,
      .bus_err, .bus_rdata);
   always #20 clk_sys = ~clk_sys;
   // log every answered bus beat and its address
   always @(posedge clk_sys) begin
      if (bus_req && (bus_ack || bus_err)) begin
         beats <= beats + 1;
         prev_a <= last_a;
         last_a <= bus_addr;
      end
   end
   // one fetch; checks answer kind, word and bus beats spent
   task fx(input [31:0] a, input e, input integer nb);
      integer n;
      integer b0;
      begin
         b0 = beats;
         cpu_req <= 1'b1;
         cpu_addr <= a;
         n = 0;
         do begin
            @(posedge clk_sys);
            n++;
         end while (cpu_ack !== 1'b1 && cpu_err !== 1'b1 && n < 200);
         `CHK(cpu_ack ^ cpu_err, 1'b1)
         `CHK(cpu_err, e)
         if (!e) `CHK(cpu_rdata, a ^ 32'hA5A5_0000)
         cpu_req <= 1'b0;
         @(posedge clk_sys);
         `CHK(beats - b0, nb)
      end
   endtask
   // register write, address and data offered together
   task axw(input [7:0] a, input [31:0] d);
      integer n;
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         n = 0;
         do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
         end while (s_axi_bvalid !== 1'b1 && n < 50);
         s_axi_bready <= 1'b0;
         `CHK(s_axi_bvalid, 1'b1)
         `CHK(s_axi_bresp, `ICF_RESP_OKAY)
         repeat (2) @(posedge clk_sys);
      end
   endtask
   // register read with expected data and response
   task axr(input [7:0] a, input [31:0] d, input [1:0] r);
      integer n;
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         n = 0;
         do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (s_axi_rvalid !== 1'b1 && n < 50);
         s_axi_rready <= 1'b0;
         `CHK(s_axi_rvalid, 1'b1)
         `CHK(s_axi_rresp, r)
         if (r == `ICF_RESP_OKAY) `CHK(s_axi_rdata, d)
         @(posedge clk_sys);
      end
   endtask
   task close_out;
      begin
         $display("compared %0d mismatches %0d", n_compared, num_errors);
         if (num_errors == 0 && n_compared > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   // hangs are cut far beyond the few hundred cycles the tests need
   initial begin
      #2000000;
      num_errors++;
      close_out;
   end
   // ********************
   // scenarios
   // ********************
   task t_config;
      axr(`ICF_REG_CONF, 32'h0000_1123, `ICF_RESP_OKAY);
      axw(`ICF_REG_CONF, 32'h0000_0000);
      axr(`ICF_REG_CONF, 32'h0000_1123, `ICF_RESP_OKAY);
      axr(8'h10, 32'h0000_0000, `ICF_RESP_SLVERR);
      $display("test config done");
   endtask
   task t_fill;
      fx(32'h0000_0104, 1'b0, 2);
      `CHK(prev_a, 32'h0000_0100)
      `CHK(last_a, 32'h0000_0104)
      fx(32'h0000_0100, 1'b0, 0);
      $display("test fill and hit done");
   endtask
   task t_repl;
      fx(32'h0000_0200, 1'b0, 2);
      fx(32'h0000_0210, 1'b0, 2);
      fx(32'h0000_0200, 1'b0, 0);
      fx(32'h0000_0220, 1'b0, 2);
      fx(32'h0000_0200, 1'b0, 0);
      fx(32'h0000_0210, 1'b0, 2);
      $display("test replacement done");
   endtask
   task t_fence;
      cpu_fence_i <= 1'b1;
      @(posedge clk_sys);
      cpu_fence_i <= 1'b0;
      @(posedge clk_sys);
      fx(32'h0000_0200, 1'b0, 2);
      $display("test fence done");
   endtask
   task t_fault;
      lat <= 4'h3;
      err_addr <= 32'h0000_0044;
      fx(32'h0000_0040, 1'b1, 2);
      fx(32'h0000_0044, 1'b1, 0);
      axw(`ICF_REG_MASK, 32'h0000_0001);
      `CHK(irq, 1'b1)
      axw(`ICF_REG_STAT, 32'h0000_0001);
      `CHK(irq, 1'b0)
      mute_addr <= 32'h0000_0080;
      fx(32'h0000_0080, 1'b1, 1);
      $display("test fill faults done");
   endtask
   task t_bypass;
      axw(`ICF_REG_CTRL, 32'h0000_0003);
      axr(`ICF_REG_CTRL, 32'h0000_0002, `ICF_RESP_OKAY);
      fx(32'h0000_0300, 1'b0, 1);
      fx(32'h0000_0304, 1'b0, 1);
      axw(`ICF_REG_CTRL, 32'h0000_0000);
      $display("test bypass done");
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      t_config;
      t_fill;
      t_repl;
      t_fence;
      t_fault;
      t_bypass;
      close_out;
   end
endmodule
